// ### core/drpm_pkg.sv
package drpm_pkg;

    // Register bus
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  OFF_FUNC        = 8'h00;
    localparam logic [7:0]  OFF_GPIO        = 8'h04;
    localparam logic [7:0]  OFF_STATUS      = 8'h08;
    localparam logic [7:0]  OFF_SWRST       = 8'h0c;

    // Function-select register fields
    localparam int          FUNC_D3_BIT     = 0;
    localparam int          FUNC_D4_BIT     = 1;
    localparam int          FUNC_A0_LSB     = 2;
    localparam int          FUNC_A1_BIT     = 4;
    localparam logic [1:0]  A0_GPIO         = 2'h0;
    localparam logic [1:0]  A0_ANALOG       = 2'h1;
    localparam logic [1:0]  A0_COMP         = 2'h2;

    // Port control register fields
    localparam int          GPIO_D3_DIR     = 0;
    localparam int          GPIO_D3_OUT     = 1;
    localparam int          GPIO_D4_ODEN    = 2;
    localparam int          GPIO_D4_OUT     = 3;
    localparam int          GPIO_A0_DIR     = 4;
    localparam int          GPIO_A0_OUT     = 5;
    localparam int          GPIO_A1_DIR     = 6;
    localparam int          GPIO_A1_OUT     = 7;
    localparam logic [7:0]  GPIO_RESET      = 8'h00;

    // Reset release
    localparam int          RST_RELEASE_CYCLES = 16;

    // Test access port
    localparam int          IR_W            = 4;
    localparam int          DR_W            = 32;
    localparam logic [3:0]  IR_CAPTURE      = 4'h1;
    localparam logic [3:0]  IR_IDCODE       = 4'h2;
    localparam logic [3:0]  IR_BYPASS       = 4'hf;
    // Arbitrary identification value
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h0000_0001;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } drpm_tap_t;

endpackage : drpm_pkg

// ### core/drpm_rst_seq.sv
`timescale 1ns/1ps
module drpm_rst_seq
    import drpm_pkg::*;
#(
    parameter int RELEASE_CYCLES = RST_RELEASE_CYCLES
) (
    // Clock and power-on reset
    input  wire logic mclk,
    input  wire logic reset,
    // Reset sources
    input  wire logic extResetNPinIn,
    input  wire logic extResetEnable,
    input  wire logic watchdogReset,
    input  wire logic swReset,
    // Internal reset
    output logic      sysReset
);
    localparam int CNT_W = $clog2(RELEASE_CYCLES + 1);

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic [CNT_W-1:0] cnt;
        logic             active;
    } drpm_seq_state_t;

    localparam drpm_seq_state_t SEQ_RST = '{sync1: 1'b1, sync2: 1'b1,
                                            cnt: '0, active: 1'b1};

    drpm_seq_state_t s_q;
    drpm_seq_state_t s_d;
    logic            srcActive;

    always_comb begin
        s_d       = s_q;
        s_d.sync1 = extResetNPinIn;
        s_d.sync2 = s_q.sync1;
        // Pin level counts only in its reset function
        srcActive = (extResetEnable && !s_q.sync2) || watchdogReset || swReset;
        if (srcActive) begin
            s_d.active = 1'b1;
            s_d.cnt    = '0;
        end else if (s_q.active) begin
            if (s_q.cnt == CNT_W'(RELEASE_CYCLES - 1)) begin
                s_d.active = 1'b0;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= SEQ_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sysReset = s_q.active;

endmodule : drpm_rst_seq

// ### core/drpm_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Test-mode-select steps the test access port state machine.
// - Test-mode-select is sampled on each test clock rising edge.
// - After reset the shared pin is in test-mode-select function.
// - Reset pin held low keeps the device in reset.
// - Internal reset releases synchronously after a fixed count of clocks.
// - After reset the reset pin is in its reset-input function.
// - Reset pin as port line is input or open-drain, never push-pull.
// - Reset pin level is ignored while in port function.
// - Then only power-on, watchdog and software reset act.
// - Port A line 0 comes up as a port pin after reset.
// - Port A line 1 comes up as a port pin after reset.
// - Line 0 analog mode routes to converter channel 0 and comparator input 3.
// - Line 1 analog mode routes to converter channel 1 and comparator input 0.
// - Line 0 comparator alternate drives comparator C output.
// - Test clock times the test logic and serial shifting.
// - Test data output driven only in shift states, changing on falling edge.
module drpm_top
    import drpm_pkg::*;
#(
    parameter int          RELEASE_CYCLES = RST_RELEASE_CYCLES,
    parameter logic [31:0] ID_CODE        = ID_CODE_DEFAULT
) (
    // Clock and power-on reset
    input  wire logic              mclk,
    input  wire logic              reset,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    // Test port
    input  wire logic              tck,
    input  wire logic              tdi,
    output logic                   tdoOut,
    output logic                   tdoOe,
    // Test-mode-select / port D line 3
    input  wire logic              portDLine3In,
    output logic                   portDLine3Out,
    output logic                   portDLine3Oe,
    // External reset / port D line 4
    input  wire logic              extResetNPinIn,
    output logic                   portDLine4Out,
    output logic                   portDLine4Oe,
    // Port A line 0
    input  wire logic              portALine0In,
    output logic                   portALine0Out,
    output logic                   portALine0Oe,
    // Port A line 1
    input  wire logic              portALine1In,
    output logic                   portALine1Out,
    output logic                   portALine1Oe,
    // Analog routing
    input  wire logic              compCOutput,
    output logic                   convAChan0En,
    output logic                   compAInput3En,
    output logic                   convAChan1En,
    output logic                   compAInput0En,
    // Reset sources and internal reset
    input  wire logic              watchdogReset,
    output logic                   sysResetOut
);

    typedef struct packed {
        logic            tckPrev;
        drpm_tap_t       tap;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] irSh;
        logic [DR_W-1:0] drSh;
        logic            fD3Gpio;
        logic            fD4Gpio;
        logic [1:0]      fA0;
        logic            fA1Analog;
        logic [7:0]      gpioCtl;
        logic            swRst;
        logic            sysRst;
        logic [31:0]     rdata;
        logic            tdo;
        logic            tdoOe;
        logic            d3Out;
        logic            d3Oe;
        logic            d4Out;
        logic            d4Oe;
        logic            a0Out;
        logic            a0Oe;
        logic            a1Out;
        logic            a1Oe;
        logic            convA0;
        logic            compA3;
        logic            convA1;
        logic            compA0;
    } drpm_top_state_t;

    localparam drpm_top_state_t TOP_RST = '{
        tckPrev: 1'b0, tap: TAP_RESET, ir: IR_IDCODE, irSh: '0, drSh: '0,
        fD3Gpio: 1'b0, fD4Gpio: 1'b0, fA0: A0_GPIO, fA1Analog: 1'b0,
        gpioCtl: GPIO_RESET, swRst: 1'b0, sysRst: 1'b1, rdata: '0,
        tdo: 1'b0, tdoOe: 1'b0, d3Out: 1'b0, d3Oe: 1'b0, d4Out: 1'b0,
        d4Oe: 1'b0, a0Out: 1'b0, a0Oe: 1'b0, a1Out: 1'b0, a1Oe: 1'b0,
        convA0: 1'b0, compA3: 1'b0, convA1: 1'b0, compA0: 1'b0};

    drpm_top_state_t s_q;
    drpm_top_state_t s_d;
    logic            sysReset;
    logic            tckRise;
    logic            tckFall;
    logic            tmsEff;

    drpm_rst_seq #(
        .RELEASE_CYCLES (RELEASE_CYCLES)
    ) u_rst_seq (
        .mclk           (mclk),
        .reset          (reset),
        .extResetNPinIn (extResetNPinIn),
        .extResetEnable (!s_q.fD4Gpio),
        .watchdogReset  (watchdogReset),
        .swReset        (s_q.swRst),
        .sysReset       (sysReset)
    );

    function automatic drpm_tap_t tapNext(input drpm_tap_t st, input logic tms);
        case (st)
            TAP_RESET:    tapNext = tms ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   tapNext = tms ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   tapNext = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tapNext = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tapNext = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tapNext = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tapNext = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   tapNext = tms ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   tapNext = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tapNext = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tapNext = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tapNext = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tapNext = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
            default:      tapNext = TAP_RESET;
        endcase
    endfunction : tapNext

    // Edge detection on the sampled test clock
    assign tckRise = tck && !s_q.tckPrev;
    assign tckFall = !tck && s_q.tckPrev;
    // In port function the controller sees the pull-up level
    assign tmsEff  = s_q.fD3Gpio ? 1'b1 : portDLine3In;

    always_comb begin
        s_d         = s_q;
        s_d.tckPrev = tck;
        s_d.swRst   = 1'b0;
        s_d.sysRst  = sysReset;

        // Test access port
        if (tckRise) begin
            s_d.tap = tapNext(s_q.tap, tmsEff);
            case (s_q.tap)
                TAP_RESET: begin
                    s_d.ir = IR_IDCODE;
                end
                TAP_CAP_IR: begin
                    s_d.irSh = IR_CAPTURE;
                end
                TAP_SHIFT_IR: begin
                    s_d.irSh = {tdi, s_q.irSh[IR_W-1:1]};
                end
                TAP_UPD_IR: begin
                    s_d.ir = s_q.irSh;
                end
                TAP_CAP_DR: begin
                    s_d.drSh = (s_q.ir == IR_IDCODE) ? ID_CODE : '0;
                end
                TAP_SHIFT_DR: begin
                    if (s_q.ir == IR_IDCODE) begin
                        s_d.drSh = {tdi, s_q.drSh[DR_W-1:1]};
                    end else begin
                        s_d.drSh = {s_q.drSh[DR_W-1:1], tdi};
                    end
                end
                default: begin
                end
            endcase
        end
        if (tckFall) begin
            s_d.tdoOe = (s_q.tap == TAP_SHIFT_IR) || (s_q.tap == TAP_SHIFT_DR);
            s_d.tdo   = (s_q.tap == TAP_SHIFT_IR) ? s_q.irSh[0] : s_q.drSh[0];
        end

        // Register writes
        if (regWr) begin
            case (regAddr)
                OFF_FUNC: begin
                    s_d.fD3Gpio   = regWdata[FUNC_D3_BIT];
                    s_d.fD4Gpio   = regWdata[FUNC_D4_BIT];
                    s_d.fA0       = regWdata[FUNC_A0_LSB +: 2];
                    s_d.fA1Analog = regWdata[FUNC_A1_BIT];
                end
                OFF_GPIO: begin
                    s_d.gpioCtl = regWdata[7:0];
                end
                OFF_SWRST: begin
                    s_d.swRst = regWdata[0];
                end
                default: begin
                end
            endcase
        end

        // Register reads
        s_d.rdata = '0;
        if (regRd) begin
            case (regAddr)
                OFF_FUNC: begin
                    s_d.rdata = {27'h0, s_q.fA1Analog, s_q.fA0, s_q.fD4Gpio, s_q.fD3Gpio};
                end
                OFF_GPIO: begin
                    s_d.rdata = {24'h0, s_q.gpioCtl};
                end
                OFF_STATUS: begin
                    s_d.rdata = {24'h0, s_q.tap, portDLine3In, extResetNPinIn,
                                 portALine0In, portALine1In};
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        // Port D line 3: test-mode-select or port line
        s_d.d3Out = s_q.gpioCtl[GPIO_D3_OUT];
        s_d.d3Oe  = s_q.fD3Gpio && s_q.gpioCtl[GPIO_D3_DIR];

        // Port D line 4: open-drain only, drives low or releases
        s_d.d4Out = 1'b0;
        s_d.d4Oe  = s_q.fD4Gpio && s_q.gpioCtl[GPIO_D4_ODEN]
                    && !s_q.gpioCtl[GPIO_D4_OUT];

        // Port A line 0
        s_d.convA0 = (s_q.fA0 == A0_ANALOG);
        s_d.compA3 = (s_q.fA0 == A0_ANALOG);
        case (s_q.fA0)
            A0_ANALOG: begin
                s_d.a0Out = 1'b0;
                s_d.a0Oe  = 1'b0;
            end
            A0_COMP: begin
                s_d.a0Out = compCOutput;
                s_d.a0Oe  = 1'b1;
            end
            default: begin
                s_d.a0Out = s_q.gpioCtl[GPIO_A0_OUT];
                s_d.a0Oe  = s_q.gpioCtl[GPIO_A0_DIR];
            end
        endcase

        // Port A line 1
        s_d.convA1 = s_q.fA1Analog;
        s_d.compA0 = s_q.fA1Analog;
        s_d.a1Out  = s_q.gpioCtl[GPIO_A1_OUT];
        s_d.a1Oe   = !s_q.fA1Analog && s_q.gpioCtl[GPIO_A1_DIR];
    end

    // Internal reset returns every pin to its primary function
    always_ff @(posedge mclk) begin
        if (reset || sysReset) begin
            s_q <= TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata      = s_q.rdata;
    assign tdoOut        = s_q.tdo;
    assign tdoOe         = s_q.tdoOe;
    assign portDLine3Out = s_q.d3Out;
    assign portDLine3Oe  = s_q.d3Oe;
    assign portDLine4Out = s_q.d4Out;
    assign portDLine4Oe  = s_q.d4Oe;
    assign portALine0Out = s_q.a0Out;
    assign portALine0Oe  = s_q.a0Oe;
    assign portALine1Out = s_q.a1Out;
    assign portALine1Oe  = s_q.a1Oe;
    assign convAChan0En  = s_q.convA0;
    assign compAInput3En = s_q.compA3;
    assign convAChan1En  = s_q.convA1;
    assign compAInput0En = s_q.compA0;
    assign sysResetOut   = s_q.sysRst;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_tapHold;
        !tckRise && !sysReset |=> $stable(s_q.tap);
    endproperty
    a_tapHold: assert property (p_tapHold)
        else $error("controller moved without a test clock rising edge");

    property p_tapStep;
        tckRise && !sysReset && !s_q.fD3Gpio && s_q.tap == TAP_IDLE && portDLine3In
            |=> s_q.tap == TAP_SEL_DR;
    endproperty
    a_tapStep: assert property (p_tapStep)
        else $error("controller did not leave idle on high select");

    property p_tdoEdge;
        !sysReset && $changed(s_q.tdoOe) |-> $past(tckFall);
    endproperty
    a_tdoEdge: assert property (p_tdoEdge)
        else $error("test data output enable changed off the falling edge");

    property p_resetPin;
        (!extResetNPinIn && !s_q.fD4Gpio && !sysReset)[*3] |=> sysReset;
    endproperty
    a_resetPin: assert property (p_resetPin)
        else $error("low reset pin did not raise the internal reset");

    property p_release;
        $fell(sysReset) |-> $past(sysReset, RELEASE_CYCLES);
    endproperty
    a_release: assert property (p_release)
        else $error("internal reset released before its count");

    property p_primary;
        $fell(sysReset) |-> !s_q.fD3Gpio && !s_q.fD4Gpio && s_q.fA0 == A0_GPIO
            && !s_q.fA1Analog;
    endproperty
    a_primary: assert property (p_primary)
        else $error("pin functions not primary at reset release");

    property p_openDrain;
        portDLine4Oe |-> !portDLine4Out && $past(s_q.fD4Gpio);
    endproperty
    a_openDrain: assert property (p_openDrain)
        else $error("reset pin driven high or outside port function");

    property p_pinIgnored;
        (s_q.fD4Gpio && !extResetNPinIn && !watchdogReset && !s_q.swRst && !sysReset)[*4]
            |=> !sysReset;
    endproperty
    a_pinIgnored: assert property (p_pinIgnored)
        else $error("reset pin level reset the device in port function");

    property p_watchdog;
        watchdogReset |=> sysReset;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog request did not reset the device");

    property p_analog0;
        !sysReset && s_q.fA0 == A0_ANALOG |=> convAChan0En && compAInput3En && !portALine0Oe;
    endproperty
    a_analog0: assert property (p_analog0)
        else $error("line 0 analog routing missing");

    property p_analog1;
        !sysReset && s_q.fA1Analog |=> convAChan1En && compAInput0En && !portALine1Oe;
    endproperty
    a_analog1: assert property (p_analog1)
        else $error("line 1 analog routing missing");

    property p_compOut;
        !sysReset && s_q.fA0 == A0_COMP |=> portALine0Oe && portALine0Out == $past(compCOutput);
    endproperty
    a_compOut: assert property (p_compOut)
        else $error("comparator output not driven on line 0");

    property p_covRelease;
        $fell(sysReset);
    endproperty
    c_covRelease: cover property (p_covRelease);

    property p_covShift;
        s_q.tap == TAP_SHIFT_DR && tdoOe;
    endproperty
    c_covShift: cover property (p_covShift);

    property p_covComp;
        portALine0Oe && s_q.fA0 == A0_COMP;
    endproperty
    c_covComp: cover property (p_covComp);

endmodule : drpm_top

// ### dv/drpm_probe.sv
`timescale 1ns/1ps
module drpm_probe (
    // System clock
    input  wire logic mclk,
    // Test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdoOut,
    input  wire logic tdoOe,
    // Board reset, pulled up when released
    output logic      extResetN
);
    initial begin
        tck       = 1'b0;
        tms       = 1'b1;
        tdi       = 1'b1;
        extResetN = 1'b1;
    end

    // One test clock period; high level lasts four system clocks, low level seven or more
    task automatic step(input logic tmsV, input logic tdiV, output logic tdoV, output logic oeV);
        @(posedge mclk);
        tms <= tmsV;
        tdi <= tdiV;
        repeat (2) @(posedge mclk);
        tck <= 1'b1;
        repeat (4) @(posedge mclk);
        tck <= 1'b0;
        tms <= 1'b1;
        tdi <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        tdoV = tdoOut;
        oeV  = tdoOe;
    endtask : step

    task automatic setReset(input logic v);
        @(posedge mclk);
        extResetN <= v;
    endtask : setReset
endmodule : drpm_probe

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin badCount++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
    import drpm_pkg::*;
    localparam int          RELEASE = 4;
    localparam logic [31:0] ID      = 32'h0000_0a5c; // Arbitrary value
    logic              mclk, reset, regWr, regRd, tck, tdi, tdoOut, tdoOe;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, d;
    logic portDLine3In, portDLine3Out, portDLine3Oe, extResetN, portDLine4Out, portDLine4Oe;
    logic portALine0In, portALine0Out, portALine0Oe, portALine1In, portALine1Out, portALine1Oe;
    logic compCOutput, convAChan0En, compAInput3En, convAChan1En, compAInput0En;
    logic watchdogReset, sysResetOut, t, o;
    int   badCount, compares, n;

    drpm_top #(.RELEASE_CYCLES(RELEASE), .ID_CODE(ID)) DUT (
        .mclk, .reset, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .tck, .tdi, .tdoOut, .tdoOe, .portDLine3In, .portDLine3Out, .portDLine3Oe,
        .extResetNPinIn(extResetN), .portDLine4Out, .portDLine4Oe,
        .portALine0In, .portALine0Out, .portALine0Oe, .portALine1In, .portALine1Out,
        .portALine1Oe, .compCOutput, .convAChan0En, .compAInput3En, .convAChan1En,
        .compAInput0En, .watchdogReset, .sysResetOut
    );
    drpm_probe probe (.mclk, .tck, .tms(portDLine3In), .tdi, .tdoOut, .tdoOe, .extResetN);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic settle(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : settle

    task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= v;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        v = regRdata;
    endtask : regRead

    // Bounded wait for the internal reset to reach a level
    task automatic waitReset(input logic level, input int limit, output int c);
        c = 0;
        while (sysResetOut !== level && c < limit) begin
            settle(1);
            c++;
        end
        if (sysResetOut !== level) begin
            badCount++;
            $display("CHECK FAILED sysResetOut wait expected %0h seen %0h", level, sysResetOut);
            end_sim();
        end
    endtask : waitReset

    task automatic testDefaults();
        regRead(OFF_FUNC, d);
        `CHK("function selects", 32'h0, d)
        settle(1);
        `CHK("read data one cycle", 32'h0, regRdata)
        `CHK("test select drive", 1'b0, portDLine3Oe)
        `CHK("reset pin drive", 1'b0, portDLine4Oe)
        `CHK("line0 routes", 3'h0, {convAChan0En, compAInput3En, portALine0Oe})
        `CHK("line1 routes", 3'h0, {convAChan1En, compAInput0En, portALine1Oe})
        regRead(OFF_STATUS, d);
        `CHK("line pins", 2'h2, d[1:0])
        regRead(8'h10, d);
        `CHK("unmapped read", 32'h0, d)
        $display("test defaults done");
    endtask : testDefaults

    task automatic testTap();
        logic [31:0] id;
        repeat (5) probe.step(1'b1, 1'b1, t, o);
        regRead(OFF_STATUS, d);
        `CHK("state after five", 4'(TAP_RESET), d[7:4])
        probe.step(1'b0, 1'b1, t, o);
        regRead(OFF_STATUS, d);
        `CHK("state idle", 4'(TAP_IDLE), d[7:4])
        `CHK("tdo idle enable", 1'b0, o)
        probe.step(1'b1, 1'b1, t, o);
        probe.step(1'b0, 1'b1, t, o);
        probe.step(1'b0, 1'b0, t, o);
        `CHK("tdo shift enable", 1'b1, o)
        id[0] = t;
        for (int i = 1; i < 32; i++) begin
            probe.step(1'b0, 1'b0, t, o);
            id[i] = t;
        end
        `CHK("identification", ID, id)
        probe.step(1'b1, 1'b0, t, o);
        `CHK("tdo exit enable", 1'b0, o)
        probe.step(1'b1, 1'b1, t, o);
        probe.step(1'b0, 1'b1, t, o);
        $display("test tap done");
    endtask : testTap

    task automatic testPortLines();
        regWrite(OFF_FUNC, 32'h1);
        regWrite(OFF_GPIO, 32'hf3);
        settle(2);
        `CHK("line3 drive", 2'h3, {portDLine3Oe, portDLine3Out})
        `CHK("line0 drive", 2'h3, {portALine0Oe, portALine0Out})
        `CHK("line1 drive", 2'h3, {portALine1Oe, portALine1Out})
        probe.step(1'b0, 1'b1, t, o);
        regRead(OFF_STATUS, d);
        `CHK("select in port function", 4'(TAP_SEL_DR), d[7:4])
        $display("test port lines done");
    endtask : testPortLines

    task automatic testExtReset();
        regWrite(OFF_FUNC, 32'h14);
        probe.setReset(1'b0);
        waitReset(1'b1, 10, n);
        settle(6);
        `CHK("reset held", 1'b1, sysResetOut)
        probe.setReset(1'b1);
        waitReset(1'b0, RELEASE + 12, n);
        `CHK("release count", RELEASE + 3, n)
        regRead(OFF_FUNC, d);
        `CHK("selects after pin reset", 32'h0, d)
        $display("test external reset done");
    endtask : testExtReset

    task automatic testPortReset();
        regWrite(OFF_FUNC, 32'h2);
        regWrite(OFF_GPIO, 32'h4);
        settle(2);
        `CHK("open drain low", 2'h2, {portDLine4Oe, portDLine4Out})
        regWrite(OFF_GPIO, 32'hc);
        settle(2);
        `CHK("open drain released", 2'h0, {portDLine4Oe, portDLine4Out})
        probe.setReset(1'b0);
        settle(10);
        `CHK("pin ignored", 1'b0, sysResetOut)
        probe.setReset(1'b1);
        @(posedge mclk);
        watchdogReset <= 1'b1;
        @(posedge mclk);
        watchdogReset <= 1'b0;
        waitReset(1'b1, 4, n);
        `CHK("watchdog reset", 1'b1, sysResetOut)
        waitReset(1'b0, RELEASE + 8, n);
        regWrite(OFF_SWRST, 32'h1);
        waitReset(1'b1, 6, n);
        `CHK("software reset", 1'b1, sysResetOut)
        waitReset(1'b0, RELEASE + 8, n);
        $display("test port reset done");
    endtask : testPortReset

    task automatic testAnalog();
        regWrite(OFF_FUNC, 32'h14);
        settle(2);
        `CHK("line0 analog", 2'h3, {convAChan0En, compAInput3En})
        `CHK("line1 analog", 2'h3, {convAChan1En, compAInput0En})
        regWrite(OFF_FUNC, 32'h8);
        compCOutput <= 1'b1;
        settle(3);
        `CHK("comparator high", 2'h3, {portALine0Oe, portALine0Out})
        `CHK("line0 unrouted", 2'h0, {convAChan0En, compAInput3En})
        @(posedge mclk);
        compCOutput <= 1'b0;
        settle(2);
        `CHK("comparator low", 1'b0, portALine0Out)
        $display("test analog done");
    endtask : testAnalog

    initial begin
        badCount      = 0;
        compares      = 0;
        reset         = 1'b1;
        regWr         = 1'b0;
        regRd         = 1'b0;
        regAddr       = 8'h00;
        regWdata      = 32'h0;
        portALine0In  = 1'b1;
        portALine1In  = 1'b0;
        compCOutput   = 1'b0;
        watchdogReset = 1'b0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        waitReset(1'b0, RELEASE + 10, n);
        testDefaults();
        testTap();
        testPortLines();
        testExtReset();
        testPortReset();
        testAnalog();
        end_sim();
    end
endmodule : tb_top
